// ===== core/adcrr_pkg.sv
package adcrr_pkg;
    // Register byte offsets
    localparam logic [7:0]  RESULT_OFS     = 8'h00;
    localparam logic [7:0]  CONTROL_OFS    = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFS   = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFS   = 8'h0c;
    // Result register fields
    localparam int          VALID_BIT      = 21;
    localparam int          OVERRUN_BIT    = 20;
    localparam int          TAG_LSB        = 16;
    localparam int          TAG_W          = 4;
    localparam int          DATA_W         = 16;
    localparam int          SAMPLE_W       = 12;
    // Control register: alignment select
    localparam int          ALIGN_BIT      = 0;
    // Interrupt status bits
    localparam int          IRQ_W          = 2;
    localparam int          IRQ_DONE_BIT   = 0;
    localparam int          IRQ_OVR_BIT    = 1;
    // Reset values
    localparam logic [31:0] RESULT_RST     = 32'h0000_0000;
    localparam logic        ALIGN_RST      = 1'b0;
    localparam logic [1:0]  IRQ_RST        = 2'h0;

    typedef struct packed {
        logic                valid;
        logic                overrun;
        logic [TAG_W-1:0]    tag;
        logic [DATA_W-1:0]   data;
    } adcrr_result_s;

    typedef struct packed {
        logic                load;
        logic [TAG_W-1:0]    channel;
        logic [SAMPLE_W-1:0] sample;
    } adcrr_conv_s;

    typedef struct packed {
        adcrr_result_s       res;
        logic                align_left;
        logic [IRQ_W-1:0]    irq_stat;
        logic [IRQ_W-1:0]    irq_mask;
        logic [31:0]         prdata;
        logic                pslverr;
    } adcrr_state_s;
endpackage

// ===== core/adcrr_result_reg.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
// Notes on behaviour
// - Valid flag bit 21 set on load
// - Reading result clears valid flag
// - Overrun bit 20 set if unread result
// - Read clears overrun; writes ignored
// - Bits 19:16 give result channel number
// - Bits 15:0 carry 12-bit result
// - Software alignment choice places result
module adcrr_result_reg (
    input  wire logic                CLK_IN,          // 250 MHz clock
    input  wire logic                RST_B_IN,        // Async reset, low
    input  wire logic                PSEL_IN,         // APB select
    input  wire logic                PENABLE_IN,      // APB enable
    input  wire logic                PWRITE_IN,       // APB write
    input  wire logic [7:0]          PADDR_IN,        // APB byte address
    input  wire logic [31:0]         PWDATA_IN,       // APB write data
    output logic      [31:0]         PRDATA_OUT,      // APB read data
    output logic                     PREADY_OUT,      // APB ready
    output logic                     PSLVERR_OUT,     // APB error
    input  wire adcrr_pkg::adcrr_conv_s CONV_IN,      // Sequencer load
    output logic                     IRQ_OUT          // Interrupt level
);
    adcrr_pkg::adcrr_state_s state_q;
    adcrr_pkg::adcrr_state_s state_d;
    logic                    access;
    logic                    rd_result;
    logic                    wr;
    logic                    mapped;
    logic [adcrr_pkg::DATA_W-1:0] placed;
    logic [adcrr_pkg::IRQ_W-1:0]  irq_set;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign access    = PSEL_IN && PENABLE_IN;
    assign wr        = access && PWRITE_IN;
    assign rd_result = access && !PWRITE_IN && PADDR_IN == adcrr_pkg::RESULT_OFS;
    assign mapped    = PADDR_IN == adcrr_pkg::RESULT_OFS || PADDR_IN == adcrr_pkg::CONTROL_OFS
                    || PADDR_IN == adcrr_pkg::IRQ_STAT_OFS || PADDR_IN == adcrr_pkg::IRQ_MASK_OFS;

    // Left alignment puts the sample in the top 12 bits
    always_comb begin
        if (state_q.align_left) begin
            placed = {CONV_IN.sample, 4'h0};
        end else begin
            placed = {4'h0, CONV_IN.sample};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_d         = state_q;
        state_d.prdata  = 32'h0000_0000;
        state_d.pslverr = 1'b0;
        irq_set         = '0;
        if (rd_result) begin
            state_d.res.valid   = 1'b0;
            state_d.res.overrun = 1'b0;
        end
        if (CONV_IN.load) begin
            state_d.res.overrun = state_q.res.valid;
            state_d.res.valid   = 1'b1;
            state_d.res.tag     = CONV_IN.channel;
            state_d.res.data    = placed;
            irq_set[adcrr_pkg::IRQ_DONE_BIT] = 1'b1;
            if (state_q.res.valid) begin
                irq_set[adcrr_pkg::IRQ_OVR_BIT] = 1'b1;
            end
        end
        state_d.irq_stat = state_q.irq_stat | irq_set;
        if (access && !PWRITE_IN) begin
            unique case (PADDR_IN)
                adcrr_pkg::RESULT_OFS:   state_d.prdata = {10'h000, state_q.res};
                adcrr_pkg::CONTROL_OFS:  state_d.prdata = {31'h0, state_q.align_left};
                adcrr_pkg::IRQ_STAT_OFS: state_d.prdata = {30'h0, state_q.irq_stat};
                adcrr_pkg::IRQ_MASK_OFS: state_d.prdata = {30'h0, state_q.irq_mask};
                default:                 state_d.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            // Result register ignores writes
            if (PADDR_IN == adcrr_pkg::CONTROL_OFS) begin
                state_d.align_left = PWDATA_IN[adcrr_pkg::ALIGN_BIT];
            end
            if (PADDR_IN == adcrr_pkg::IRQ_MASK_OFS) begin
                state_d.irq_mask = PWDATA_IN[adcrr_pkg::IRQ_W-1:0];
            end
            if (PADDR_IN == adcrr_pkg::IRQ_STAT_OFS) begin
                // Set from a same-cycle event wins over the clear
                state_d.irq_stat = (state_q.irq_stat & ~PWDATA_IN[adcrr_pkg::IRQ_W-1:0])
                                 | irq_set;
            end
            if (!mapped) begin
                state_d.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_q <= '{res: adcrr_pkg::RESULT_RST[21:0], align_left: adcrr_pkg::ALIGN_RST,
                         irq_stat: adcrr_pkg::IRQ_RST, irq_mask: adcrr_pkg::IRQ_RST,
                         prdata: 32'h0000_0000, pslverr: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: zero-wait APB, read data driven combinationally from state_q during access
    assign PREADY_OUT  = 1'b1;
    assign PRDATA_OUT  = rd_data_now();
    assign PSLVERR_OUT = access && !mapped;
    assign IRQ_OUT     = |(state_q.irq_stat & state_q.irq_mask);

    function automatic logic [31:0] rd_data_now();
        logic [31:0] v;
        v = 32'h0000_0000;
        if (access && !PWRITE_IN) begin
            if (PADDR_IN == adcrr_pkg::RESULT_OFS) begin
                v = {10'h000, state_q.res};
            end else if (PADDR_IN == adcrr_pkg::CONTROL_OFS) begin
                v = {31'h0, state_q.align_left};
            end else if (PADDR_IN == adcrr_pkg::IRQ_STAT_OFS) begin
                v = {30'h0, state_q.irq_stat};
            end else if (PADDR_IN == adcrr_pkg::IRQ_MASK_OFS) begin
                v = {30'h0, state_q.irq_mask};
            end
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_load_sets_valid: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load |=> state_q.res.valid)
        else $error("valid not set after load");
    a_read_clears_valid: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result && !CONV_IN.load |=> !state_q.res.valid)
        else $error("valid not cleared by read");
    a_overrun_set: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && state_q.res.valid |=> state_q.res.overrun)
        else $error("overrun missed");
    a_overrun_clear: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result && !CONV_IN.load |=> !state_q.res.overrun)
        else $error("overrun not cleared by read");
    a_tag_loaded: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load |=> state_q.res.tag == $past(CONV_IN.channel))
        else $error("channel tag wrong");
    a_data_right: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && !state_q.align_left |=> state_q.res.data == {4'h0, $past(CONV_IN.sample)})
        else $error("right aligned data wrong");
    a_data_left: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && state_q.align_left |=> state_q.res.data == {$past(CONV_IN.sample), 4'h0})
        else $error("left aligned data wrong");
    a_reserved_zero: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result |-> PRDATA_OUT[31:22] == 10'h000)
        else $error("reserved bits not zero");
    a_load_wins: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result && CONV_IN.load |=> state_q.res.valid)
        else $error("read beat load");
    a_irq_level: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && state_q.irq_mask[adcrr_pkg::IRQ_DONE_BIT] |=> IRQ_OUT)
        else $error("irq level wrong");

    // Bus response
    a_err_mapped: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        access && mapped |-> !PSLVERR_OUT)
        else $error("error on mapped access");

    a_err_unmapped: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        access && !mapped |-> PSLVERR_OUT)
        else $error("no error on unmapped access");

    a_err_idle: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !access |-> !PSLVERR_OUT)
        else $error("error outside access");

    a_rdata_idle: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !access |-> PRDATA_OUT == 32'h0000_0000)
        else $error("read data outside access");

    a_rdata_write: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        wr |-> PRDATA_OUT == 32'h0000_0000)
        else $error("read data on write");

    a_unmapped_zero: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        access && !PWRITE_IN && !mapped |-> PRDATA_OUT == 32'h0000_0000)
        else $error("unmapped read data not zero");

    // Result read fields
    a_valid_rd: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result |-> PRDATA_OUT[adcrr_pkg::VALID_BIT] == state_q.res.valid)
        else $error("valid bit misplaced");

    a_overrun_rd: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result |-> PRDATA_OUT[adcrr_pkg::OVERRUN_BIT] == state_q.res.overrun)
        else $error("overrun bit misplaced");

    a_tag_rd: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result |-> PRDATA_OUT[19:16] == state_q.res.tag)
        else $error("tag bits misplaced");

    a_data_rd: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result |-> PRDATA_OUT[15:0] == state_q.res.data)
        else $error("data bits misplaced");

    // Result state
    a_valid_holds: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !CONV_IN.load && !rd_result |=> state_q.res.valid == $past(state_q.res.valid))
        else $error("valid changed without cause");

    a_overrun_holds: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !CONV_IN.load && !rd_result |=> state_q.res.overrun == $past(state_q.res.overrun))
        else $error("overrun changed without cause");

    a_tag_holds: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !CONV_IN.load |=> $stable(state_q.res.tag))
        else $error("tag changed without load");

    a_data_holds: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !CONV_IN.load |=> $stable(state_q.res.data))
        else $error("data changed without load");

    a_overrun_none: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && !state_q.res.valid |=> !state_q.res.overrun)
        else $error("overrun set without unread data");

    a_ovr_needs_valid: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        state_q.res.overrun |-> state_q.res.valid)
        else $error("overrun without valid");

    a_valid_rise: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        $rose(state_q.res.valid) |-> $past(CONV_IN.load))
        else $error("valid rose without load");

    a_overrun_rise: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        $rose(state_q.res.overrun) |-> $past(CONV_IN.load))
        else $error("overrun rose without load");

    a_valid_fall: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        $fell(state_q.res.valid) |-> $past(rd_result))
        else $error("valid fell without read");

    a_overrun_fall: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        $fell(state_q.res.overrun) |-> $past(rd_result))
        else $error("overrun fell without read");

    a_result_ro: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        wr && PADDR_IN == adcrr_pkg::RESULT_OFS && !CONV_IN.load |=> $stable(state_q.res))
        else $error("result register written");

    a_right_top_zero: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && !state_q.align_left |=> state_q.res.data[15:12] == 4'h0)
        else $error("right aligned top not zero");

    a_left_low_zero: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && state_q.align_left |=> state_q.res.data[3:0] == 4'h0)
        else $error("left aligned low not zero");

    a_collide_ovr: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result && CONV_IN.load && state_q.res.valid |=> state_q.res.overrun)
        else $error("overrun lost on collision");

    a_collide_tag: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result && CONV_IN.load |=> state_q.res.tag == $past(CONV_IN.channel))
        else $error("tag lost on collision");

    a_collide_data: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rd_result && CONV_IN.load |=> state_q.res.data != 16'h0000 || $past(CONV_IN.sample) == 12'h000)
        else $error("data lost on collision");

    // Control and interrupt registers
    a_align_write: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        wr && PADDR_IN == adcrr_pkg::CONTROL_OFS
        |=> state_q.align_left == $past(PWDATA_IN[adcrr_pkg::ALIGN_BIT]))
        else $error("alignment write lost");

    a_align_holds: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !(wr && PADDR_IN == adcrr_pkg::CONTROL_OFS) |=> $stable(state_q.align_left))
        else $error("alignment changed without write");

    a_ctrl_read: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        access && !PWRITE_IN && PADDR_IN == adcrr_pkg::CONTROL_OFS
        |-> PRDATA_OUT == {31'h0, state_q.align_left})
        else $error("control read wrong");

    a_mask_write: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        wr && PADDR_IN == adcrr_pkg::IRQ_MASK_OFS
        |=> state_q.irq_mask == $past(PWDATA_IN[adcrr_pkg::IRQ_W-1:0]))
        else $error("mask write lost");

    a_mask_holds: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !(wr && PADDR_IN == adcrr_pkg::IRQ_MASK_OFS) |=> $stable(state_q.irq_mask))
        else $error("mask changed without write");

    a_mask_read: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        access && !PWRITE_IN && PADDR_IN == adcrr_pkg::IRQ_MASK_OFS
        |-> PRDATA_OUT == {30'h0, state_q.irq_mask})
        else $error("mask read wrong");

    a_stat_read: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        access && !PWRITE_IN && PADDR_IN == adcrr_pkg::IRQ_STAT_OFS
        |-> PRDATA_OUT == {30'h0, state_q.irq_stat})
        else $error("status read wrong");

    a_done_set: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load |=> state_q.irq_stat[adcrr_pkg::IRQ_DONE_BIT])
        else $error("done status not set");

    a_ovr_stat_set: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && state_q.res.valid |=> state_q.irq_stat[adcrr_pkg::IRQ_OVR_BIT])
        else $error("overrun status not set");

    a_stat_clear: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        wr && PADDR_IN == adcrr_pkg::IRQ_STAT_OFS && !CONV_IN.load
        |=> (state_q.irq_stat & $past(PWDATA_IN[adcrr_pkg::IRQ_W-1:0])) == 2'h0)
        else $error("status not cleared");

    a_stat_set_wins: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        wr && PADDR_IN == adcrr_pkg::IRQ_STAT_OFS && CONV_IN.load
        |=> state_q.irq_stat[adcrr_pkg::IRQ_DONE_BIT])
        else $error("clear beat status set");

    a_stat_holds: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !CONV_IN.load && !(wr && PADDR_IN == adcrr_pkg::IRQ_STAT_OFS)
        |=> $stable(state_q.irq_stat))
        else $error("status changed without cause");

    a_stat_rise: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        $rose(state_q.irq_stat[adcrr_pkg::IRQ_DONE_BIT]) |-> $past(CONV_IN.load))
        else $error("done status rose without load");

    a_irq_masked: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        state_q.irq_mask == 2'h0 |-> !IRQ_OUT)
        else $error("irq with all masked");

    a_irq_clear: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        state_q.irq_stat == 2'h0 |-> !IRQ_OUT)
        else $error("irq with no status");

    c_overrun: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && state_q.res.valid);
    c_read_after_load: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load ##[1:20] rd_result);
    c_collide: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && rd_result);
    c_irq: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN) $rose(IRQ_OUT));
    c_left_load: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        CONV_IN.load && state_q.align_left);
endmodule

// ===== test/adc_result_data_register_bench.sv
`timescale 1ns/10ps
module adc_result_data_register_bench;
    logic                   CLK_IN     = 1'b0;
    logic                   RST_B_IN   = 1'b0;
    logic                   PSEL_IN    = 1'b0;
    logic                   PENABLE_IN = 1'b0;
    logic                   PWRITE_IN  = 1'b0;
    logic [7:0]             PADDR_IN   = 8'h00;
    logic [31:0]            PWDATA_IN  = 32'h0;
    logic [31:0]            PRDATA_OUT;
    logic                   PREADY_OUT;
    logic                   PSLVERR_OUT;
    logic                   IRQ_OUT;
    adcrr_pkg::adcrr_conv_s CONV_IN    = '0;
    int                     error_cnt  = 0;
    int                     tests_run  = 0;
    logic [15:0]            rnd        = 16'h000f;
    logic                   mv = 1'b0, mo = 1'b0, al = 1'b0, er;
    logic [3:0]             mt = 4'h0;
    logic [15:0]            md = 16'h0;
    logic [1:0]             st = 2'h0, mk = 2'h0;
    logic [31:0]            rd;

    adcrr_result_reg u_adcrr_result_reg (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
        .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
        .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
        .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .CONV_IN(CONV_IN),
        .IRQ_OUT(IRQ_OUT));

    always #2 CLK_IN = ~CLK_IN;

    ////////////////////////////////////////////////////////////////
    task test_done;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    // One APB transfer; ld pulses a sequencer load in the access cycle
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ld);
        int   n;
        logic rdy;
        n = 0;
        @(posedge CLK_IN);
        PSEL_IN   <= 1'b1;
        PWRITE_IN <= w;
        PADDR_IN  <= a;
        PWDATA_IN <= d;
        @(posedge CLK_IN);
        PENABLE_IN   <= 1'b1;
        CONV_IN.load <= ld;
        do begin
            @(negedge CLK_IN);
            n++;
            rdy = PREADY_OUT;
            rd  = PRDATA_OUT;
            er  = PSLVERR_OUT;
            @(posedge CLK_IN);
        end while (rdy !== 1'b1 && n < 16);
        if (rdy !== 1'b1) begin
            error_cnt++;
            test_done();
        end
        PSEL_IN      <= 1'b0;
        PENABLE_IN   <= 1'b0;
        CONV_IN.load <= 1'b0;
    endtask

    task lm(input logic [3:0] c, input logic [11:0] s);
        if (mv) st[1] = 1'b1;
        st[0] = 1'b1;
        mo    = mv;
        mv    = 1'b1;
        mt    = c;
        md    = al ? {s, 4'h0} : {4'h0, s};
    endtask

    task dl(input logic [3:0] c, input logic [11:0] s);
        @(posedge CLK_IN);
        CONV_IN <= {1'b1, c, s};
        @(posedge CLK_IN);
        CONV_IN <= '0;
        lm(c, s);
        #1;
        chk("irq", {31'h0, |(st & mk)}, {31'h0, IRQ_OUT});
    endtask

    task rres(input logic ld);
        apb(1'b0, adcrr_pkg::RESULT_OFS, 32'h0, ld);
        chk("result", {10'h0, mv, mo, mt, md}, rd);
        if (ld) lm(CONV_IN.channel, CONV_IN.sample);
        else {mv, mo} = 2'b00;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge CLK_IN);
        RST_B_IN <= 1'b1;
        rres(1'b0);
        apb(1'b1, adcrr_pkg::IRQ_MASK_OFS, 32'h3, 1'b0);
        mk = 2'h3;
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            dl(4'(i), rnd[11:0]);
            rres(1'b0);
            rres(1'b0);
        end
        dl(4'h3, 12'h5a5);
        dl(4'h7, 12'hfff);
        apb(1'b1, adcrr_pkg::RESULT_OFS, 32'hffff_ffff, 1'b0);
        rres(1'b0);
        rres(1'b0);
        apb(1'b0, adcrr_pkg::IRQ_STAT_OFS, 32'h0, 1'b0);
        chk("irq_stat", {30'h0, st}, rd);
        apb(1'b1, adcrr_pkg::IRQ_STAT_OFS, 32'h3, 1'b0);
        st = 2'h0;
        #1;
        chk("irq_clr", 32'h0, {31'h0, IRQ_OUT});
        apb(1'b1, adcrr_pkg::CONTROL_OFS, 32'h1, 1'b0);
        al = 1'b1;
        apb(1'b0, adcrr_pkg::CONTROL_OFS, 32'h0, 1'b0);
        chk("control", 32'h1, rd);
        dl(4'h9, 12'habc);
        rres(1'b0);
        dl(4'h2, 12'h123);
        CONV_IN.channel <= 4'h8;
        CONV_IN.sample  <= 12'h456;
        rres(1'b1);
        rres(1'b0);
        apb(1'b0, 8'h10, 32'h0, 1'b0);
        chk("unmapped", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        test_done();
    end
endmodule
